// ==== rtl/sdlcf_pkg.sv ====
// Function
// - While the check sequence goes out, line follows check output bit; check keeps clocking.
// - Insert a zero after five consecutive ones throughout the sixteen check bits.
// - An inserted zero always goes out as SPACE, whatever the check or shift bit.
// - At the sixteenth check bit with a frame pending, prepare a flag starting with SPACE.
// - Second flag bit is MARK with the in-progress flag held; then finish flag, resume data.
// - Buffer-free sets on the first flag bit after done-enable armed in the last check bit.
// - Address, command and information characters are data: stuffing and check accumulation on.
// - After the last character append check and terminating flag, then hold MARK idle.
// - One bit time after the final terminating flag bit, clear the in-progress flag.
// - Clearing the in-progress flag directly sets the buffer-free flag.
// - Inactive and send cleared: line forced to MARK, output bit held cleared.
// - Hardware makes flags and check sequence; the host supplies address, command, data.
// - Primary mode delivers every character after the last opening flag.
// - Secondary mode compares first character with station address; mismatch hunts, match sets active.
// - In secondary mode the matched address is not delivered; the next character is.
// - Frames begin and end with 01111110, which never appears inside frame contents.
// - On receive, a zero after five ones clocks neither shift nor check register.
package sdlcf_pkg;
  localparam int          ADDR_W       = 5;
  localparam int          DATA_W       = 16;
  localparam logic [4:0]  OFS_CTRL     = 5'h00;
  localparam logic [4:0]  OFS_PARAM    = 5'h04;
  localparam logic [4:0]  OFS_TXBUF    = 5'h08;
  localparam logic [4:0]  OFS_STATUS   = 5'h0C;
  localparam logic [4:0]  OFS_RXBUF    = 5'h10;
  localparam logic [4:0]  OFS_RXCHECK  = 5'h14;
  localparam int          CTRL_SEND    = 0;
  localparam int          CTRL_RXEN    = 1;
  localparam int          CTRL_SEC     = 2;
  localparam int          TXB_SOM      = 8;
  localparam int          TXB_EOM      = 9;
  localparam logic [2:0]  CTRL_RESET   = 3'h0;
  localparam logic [7:0]  PARAM_RESET  = 8'h00;
  localparam logic [9:0]  TXBUF_RESET  = 10'h000;
  localparam logic [7:0]  FLAG_PATTERN = 8'h7E;
  localparam logic [2:0]  STUFF_LIMIT  = 3'h5;
  localparam logic [2:0]  ABORT_LIMIT  = 3'h6;
  localparam logic [2:0]  ONES_MAX     = 3'h7;
  localparam logic [3:0]  CHAR_LAST    = 4'h7;
  localparam logic [3:0]  CHECK_LAST   = 4'hF;
  localparam logic [2:0]  RX_CHAR_LAST = 3'h7;
  localparam logic [15:0] CRC_POLY     = 16'h1021;
  localparam logic [15:0] CRC_PRESET   = 16'h0000;
  localparam logic        MARK         = 1'b1;
  localparam logic        SPACE        = 1'b0;

  typedef enum logic [3:0] {
    TX_IDLE  = 4'h1,
    TX_FLAG  = 4'h2,
    TX_DATA  = 4'h4,
    TX_CHECK = 4'h8
  } sdlcf_txstate_type;
endpackage : sdlcf_pkg

// ==== rtl/sdlcf_crc.sv ====
`timescale 1ns/1ps
module sdlcf_crc #(
  parameter int                WIDTH  = 16,
  parameter logic [WIDTH-1:0]  POLY   = sdlcf_pkg::CRC_POLY,
  parameter logic [WIDTH-1:0]  PRESET = sdlcf_pkg::CRC_PRESET
) (
  input  wire logic             clk,      // System clock.
  input  wire logic             rst,      // Synchronous reset, active high.
  input  wire logic             clear,    // Load the preset value.
  input  wire logic             shiftEn,  // Advance one bit.
  input  wire logic             sendOut,  // Shift the remainder out instead of accumulating.
  input  wire logic             dataIn,   // Serial data bit to accumulate.
  output logic                  checkOut, // Most significant remainder bit.
  output logic      [WIDTH-1:0] value     // Whole remainder.
);
  import sdlcf_pkg::*;

  logic [WIDTH-1:0] crc_q;
  logic [WIDTH-1:0] crc_d;

  if (WIDTH < 2) begin : g_bad_width
    $error("sdlcf_crc needs a width of at least two");
  end

  always_comb begin
    crc_d = crc_q;
    if (clear) begin
      crc_d = PRESET;
    end else if (shiftEn) begin
      crc_d = {crc_q[WIDTH-2:0], 1'b0};
      // While sending, feedback is off so the remainder walks out untouched.
      if (!sendOut && (crc_q[WIDTH-1] ^ dataIn)) begin
        crc_d = crc_d ^ POLY;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      crc_q <= PRESET;
    end else begin
      crc_q <= crc_d;
    end
  end

  assign checkOut = crc_q[WIDTH-1];
  assign value    = crc_q;
endmodule : sdlcf_crc

// ==== rtl/sdlcf_framer.sv ====
`timescale 1ns/1ps
module sdlcf_framer (
  input  wire logic                         clk,          // System clock, 125 MHz.
  input  wire logic                         rst,          // Synchronous reset, active high.
  input  wire logic [sdlcf_pkg::ADDR_W-1:0] regAddr,      // Register byte address.
  input  wire logic [sdlcf_pkg::DATA_W-1:0] regWdata,     // Register write data.
  input  wire logic                         regWr,        // Write strobe.
  input  wire logic                         regRd,        // Read strobe.
  output logic      [sdlcf_pkg::DATA_W-1:0] regRdata,     // Read data, valid the cycle after regRd.
  input  wire logic                         txClk,        // Modem transmit bit clock.
  output logic                              serialTxLine, // Serial transmit data, 1 is MARK.
  input  wire logic                         rxClk,        // Modem receive bit clock.
  input  wire logic                         rxData        // Serial receive data.
);
  import sdlcf_pkg::*;

  logic [1:0]              txClkSync_q;
  logic [1:0]              rxClkSync_q;
  logic [1:0]              rxDataSync_q;
  logic                    txClkPrev_q;
  logic                    rxClkPrev_q;
  logic                    txTick;
  logic                    rxTick;
  logic                    rxBit;
  logic [2:0]              ctrl_q, ctrl_d;
  logic [7:0]              param_q, param_d;
  logic [9:0]              txBuf_q, txBuf_d;
  logic [DATA_W-1:0]       regRdata_q, regRdata_d;
  logic                    txBufWr;
  logic                    rxBufRead;
  logic                    ctrlSend;
  sdlcf_txstate_type       txState_q, txState_d;
  logic [3:0]              txBitCnt_q, txBitCnt_d;
  logic [7:0]              txShift_q, txShift_d;
  logic                    txShiftEom_q, txShiftEom_d;
  logic                    txShiftVal_q, txShiftVal_d;
  logic [2:0]              txOnes_q, txOnes_d;
  logic                    txOutBit_q, txOutBit_d;
  logic                    txInProg_q, txInProg_d;
  logic                    txDoneEn_q, txDoneEn_d;
  logic                    txBufFree_q, txBufFree_d;
  logic                    serialTxLine_q, serialTxLine_d;
  logic                    txBufSet;
  logic                    stuffNow;
  logic                    forceSpaceRequest;
  logic                    bitOut;
  logic                    crcClear, crcEn, crcSendOut, crcOut;
  logic [15:0]             txCrcVal;
  logic [7:0]              rxWin_q, rxWin_d, rxWinNext;
  logic [2:0]              rxOnes_q, rxOnes_d;
  logic [7:0]              rxShift_q, rxShift_d, rxShiftNext;
  logic [2:0]              rxCnt_q, rxCnt_d;
  logic                    rxFramed_q, rxFramed_d;
  logic                    rxAddrPh_q, rxAddrPh_d;
  logic                    rxMsgAct_q, rxMsgAct_d;
  logic [7:0]              rxBuf_q, rxBuf_d;
  logic                    rxDone_q, rxDone_d;
  logic                    rxOvr_q, rxOvr_d;
  logic                    rxCrcClear, rxCrcEn, charDone;
  logic [15:0]             rxCrcVal;

  function automatic logic [2:0] onesNext(input logic [2:0] ones, input logic b);
    if (!b) begin
      return 3'h0;
    end
    return (ones == ONES_MAX) ? ONES_MAX : ones + 3'h1;
  endfunction : onesNext

  // Modem clocks are asynchronous; only the second stage feeds any logic.
  always_ff @(posedge clk) begin
    if (rst) begin
      txClkSync_q  <= 2'h0;
      rxClkSync_q  <= 2'h0;
      rxDataSync_q <= 2'h3;
      txClkPrev_q  <= 1'b0;
      rxClkPrev_q  <= 1'b0;
    end else begin
      txClkSync_q  <= {txClkSync_q[0], txClk};
      rxClkSync_q  <= {rxClkSync_q[0], rxClk};
      rxDataSync_q <= {rxDataSync_q[0], rxData};
      txClkPrev_q  <= txClkSync_q[1];
      rxClkPrev_q  <= rxClkSync_q[1];
    end
  end

  assign txTick    = txClkSync_q[1] & ~txClkPrev_q;
  assign rxTick    = rxClkSync_q[1] & ~rxClkPrev_q;
  assign rxBit     = rxDataSync_q[1];
  assign txBufWr   = regWr && (regAddr == OFS_TXBUF);
  assign rxBufRead = regRd && (regAddr == OFS_RXBUF);
  assign ctrlSend  = ctrl_q[CTRL_SEND];

  always_comb begin
    ctrl_d     = ctrl_q;
    param_d    = param_q;
    txBuf_d    = txBuf_q;
    regRdata_d = '0;
    if (regWr) begin
      case (regAddr)
        OFS_CTRL:  ctrl_d  = regWdata[2:0];
        OFS_PARAM: param_d = regWdata[7:0];
        OFS_TXBUF: txBuf_d = regWdata[9:0];
        default:   ctrl_d  = ctrl_q;
      endcase
    end
    if (regRd) begin
      case (regAddr)
        OFS_CTRL:    regRdata_d = {13'h0000, ctrl_q};
        OFS_PARAM:   regRdata_d = {8'h00, param_q};
        OFS_TXBUF:   regRdata_d = {6'h00, txBuf_q};
        OFS_STATUS:  regRdata_d = {11'h000, rxOvr_q, rxDone_q, rxMsgAct_q, txInProg_q, txBufFree_q};
        OFS_RXBUF:   regRdata_d = {8'h00, rxBuf_q};
        OFS_RXCHECK: regRdata_d = rxCrcVal;
        default:     regRdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_q     <= CTRL_RESET;
      param_q    <= PARAM_RESET;
      txBuf_q    <= TXBUF_RESET;
      regRdata_q <= '0;
    end else begin
      ctrl_q     <= ctrl_d;
      param_q    <= param_d;
      txBuf_q    <= txBuf_d;
      regRdata_q <= regRdata_d;
    end
  end

  assign regRdata = regRdata_q;

  assign stuffNow = (txState_q != TX_IDLE) && (txOnes_q == STUFF_LIMIT);

  always_comb begin
    txState_d         = txState_q;
    txBitCnt_d        = txBitCnt_q;
    txShift_d         = txShift_q;
    txShiftEom_d      = txShiftEom_q;
    txShiftVal_d      = txShiftVal_q;
    txOnes_d          = txOnes_q;
    txInProg_d        = txInProg_q;
    txDoneEn_d        = txDoneEn_q;
    txBufSet          = 1'b0;
    crcClear          = 1'b0;
    crcEn             = 1'b0;
    crcSendOut        = 1'b0;
    forceSpaceRequest = 1'b0;
    bitOut            = txOutBit_q;
    if (txTick) begin
      if (stuffNow) begin
        // Shift register, check register and bit counter all hold for the stuffed bit.
        forceSpaceRequest = 1'b1;
        txOnes_d          = '0;
      end else begin
        unique case (txState_q)
          TX_IDLE: begin
            bitOut = MARK;
            if (txInProg_q) begin
              txInProg_d = 1'b0;
              txBufSet   = 1'b1;
            end else if (ctrlSend && !txBufFree_q) begin
              txState_d  = TX_FLAG;
              txBitCnt_d = '0;
              txInProg_d = 1'b1;
              txDoneEn_d = 1'b1;
            end
          end
          TX_FLAG: begin
            bitOut     = FLAG_PATTERN[txBitCnt_q[2:0]];
            txOnes_d   = '0;
            crcClear   = 1'b1;
            txBitCnt_d = txBitCnt_q + 4'h1;
            if (txBitCnt_q == 4'h0) begin
              forceSpaceRequest = 1'b1;
              txDoneEn_d        = 1'b0;
              if (txDoneEn_q && !txBufFree_q) begin
                txShift_d    = txBuf_q[7:0];
                txShiftEom_d = txBuf_q[TXB_EOM];
                txShiftVal_d = 1'b1;
                txBufSet     = 1'b1;
              end
            end
            if (txBitCnt_q == CHAR_LAST) begin
              txBitCnt_d = '0;
              txState_d  = txShiftVal_q ? TX_DATA : TX_IDLE;
            end
          end
          TX_DATA: begin
            bitOut     = txShift_q[0];
            crcEn      = 1'b1;
            txOnes_d   = onesNext(txOnes_q, bitOut);
            txShift_d  = {1'b0, txShift_q[7:1]};
            txBitCnt_d = txBitCnt_q + 4'h1;
            if (txBitCnt_q == CHAR_LAST) begin
              txBitCnt_d = '0;
              // A missing next character ends the frame early rather than sending garbage.
              if (!txShiftEom_q && !txBufFree_q) begin
                txShift_d    = txBuf_q[7:0];
                txShiftEom_d = txBuf_q[TXB_EOM];
                txBufSet     = 1'b1;
              end else begin
                txState_d    = TX_CHECK;
                txShiftVal_d = 1'b0;
              end
            end
          end
          TX_CHECK: begin
            bitOut     = crcOut;
            crcEn      = 1'b1;
            crcSendOut = 1'b1;
            txOnes_d   = onesNext(txOnes_q, bitOut);
            txBitCnt_d = txBitCnt_q + 4'h1;
            if (txBitCnt_q == CHECK_LAST) begin
              txBitCnt_d = '0;
              txState_d  = TX_FLAG;
              txDoneEn_d = !txBufFree_q && txBuf_q[TXB_SOM];
            end
          end
        endcase
      end
      if (forceSpaceRequest) begin
        bitOut = SPACE;
      end
    end
    txOutBit_d     = bitOut;
    serialTxLine_d = txOutBit_d;
    // Between frames the line idles at MARK even with send set, whatever the output bit holds.
    if (!txInProg_d) begin
      serialTxLine_d = MARK;
    end
    if (!txInProg_d && !ctrlSend) begin
      txOutBit_d     = SPACE;
    end
    txBufFree_d = txBufSet ? 1'b1 : (txBufWr ? 1'b0 : txBufFree_q);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      txState_q      <= TX_IDLE;
      txBitCnt_q     <= '0;
      txShift_q      <= '0;
      txShiftEom_q   <= 1'b0;
      txShiftVal_q   <= 1'b0;
      txOnes_q       <= '0;
      txOutBit_q     <= SPACE;
      txInProg_q     <= 1'b0;
      txDoneEn_q     <= 1'b0;
      txBufFree_q    <= 1'b1;
      serialTxLine_q <= MARK;
    end else begin
      txState_q      <= txState_d;
      txBitCnt_q     <= txBitCnt_d;
      txShift_q      <= txShift_d;
      txShiftEom_q   <= txShiftEom_d;
      txShiftVal_q   <= txShiftVal_d;
      txOnes_q       <= txOnes_d;
      txOutBit_q     <= txOutBit_d;
      txInProg_q     <= txInProg_d;
      txDoneEn_q     <= txDoneEn_d;
      txBufFree_q    <= txBufFree_d;
      serialTxLine_q <= serialTxLine_d;
    end
  end

  assign serialTxLine = serialTxLine_q;

  sdlcf_crc u_txCheck (
    .clk      (clk),
    .rst      (rst),
    .clear    (crcClear),
    .shiftEn  (crcEn),
    .sendOut  (crcSendOut),
    .dataIn   (bitOut),
    .checkOut (crcOut),
    .value    (txCrcVal)
  );

  assign rxWinNext   = {rxBit, rxWin_q[7:1]};
  assign rxShiftNext = {rxBit, rxShift_q[7:1]};

  always_comb begin
    rxWin_d    = rxWin_q;
    rxOnes_d   = rxOnes_q;
    rxShift_d  = rxShift_q;
    rxCnt_d    = rxCnt_q;
    rxFramed_d = rxFramed_q;
    rxAddrPh_d = rxAddrPh_q;
    rxMsgAct_d = rxMsgAct_q;
    rxBuf_d    = rxBuf_q;
    rxDone_d   = rxDone_q;
    rxOvr_d    = rxOvr_q;
    rxCrcClear = 1'b0;
    rxCrcEn    = 1'b0;
    charDone   = 1'b0;
    if (rxBufRead) begin
      rxDone_d = 1'b0;
      rxOvr_d  = 1'b0;
    end
    if (!ctrl_q[CTRL_RXEN]) begin
      rxFramed_d = 1'b0;
      rxMsgAct_d = 1'b0;
      rxOnes_d   = '0;
    end else if (rxTick) begin
      rxWin_d  = rxWinNext;
      rxOnes_d = onesNext(rxOnes_q, rxBit);
      if (rxWinNext == FLAG_PATTERN) begin
        rxFramed_d = 1'b1;
        rxCnt_d    = '0;
        rxAddrPh_d = ctrl_q[CTRL_SEC];
        rxMsgAct_d = 1'b0;
        rxCrcClear = 1'b1;
      end else if (rxFramed_q) begin
        if (rxOnes_q == STUFF_LIMIT && rxBit == SPACE) begin
          rxShift_d = rxShift_q;
        end else if (rxOnes_q == ABORT_LIMIT && rxBit == MARK) begin
          rxFramed_d = 1'b0;
          rxMsgAct_d = 1'b0;
        end else begin
          rxShift_d = rxShiftNext;
          rxCrcEn   = 1'b1;
          rxCnt_d   = rxCnt_q + 3'h1;
          if (rxCnt_q == RX_CHAR_LAST) begin
            charDone = 1'b1;
            if (rxAddrPh_q) begin
              rxAddrPh_d = 1'b0;
              if (rxShiftNext == param_q) begin
                rxMsgAct_d = 1'b1;
              end else begin
                rxFramed_d = 1'b0;
              end
            end else begin
              rxBuf_d    = rxShiftNext;
              rxDone_d   = 1'b1;
              rxOvr_d    = rxOvr_q | rxDone_q;
              rxMsgAct_d = 1'b1;
            end
          end
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rxWin_q    <= '0;
      rxOnes_q   <= '0;
      rxShift_q  <= '0;
      rxCnt_q    <= '0;
      rxFramed_q <= 1'b0;
      rxAddrPh_q <= 1'b0;
      rxMsgAct_q <= 1'b0;
      rxBuf_q    <= '0;
      rxDone_q   <= 1'b0;
      rxOvr_q    <= 1'b0;
    end else begin
      rxWin_q    <= rxWin_d;
      rxOnes_q   <= rxOnes_d;
      rxShift_q  <= rxShift_d;
      rxCnt_q    <= rxCnt_d;
      rxFramed_q <= rxFramed_d;
      rxAddrPh_q <= rxAddrPh_d;
      rxMsgAct_q <= rxMsgAct_d;
      rxBuf_q    <= rxBuf_d;
      rxDone_q   <= rxDone_d;
      rxOvr_q    <= rxOvr_d;
    end
  end

  sdlcf_crc u_rxCheck (
    .clk      (clk),
    .rst      (rst),
    .clear    (rxCrcClear),
    .shiftEn  (rxCrcEn),
    .sendOut  (1'b0),
    .dataIn   (rxBit),
    .checkOut (),
    .value    (rxCrcVal)
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_check_line: assert property (txTick && txState_q == TX_CHECK && !stuffNow |=> serialTxLine_q == $past(crcOut))
    else $error("check bit not on the line");
  a_stuff_space: assert property (txTick && stuffNow |=> serialTxLine_q == SPACE && txShift_q == $past(txShift_q))
    else $error("stuffed bit not SPACE or shifter moved");
  a_flag_lead: assert property (txTick && txState_q == TX_FLAG && txBitCnt_q == 4'h0 && !stuffNow |=>
    serialTxLine_q == SPACE && txInProg_q) else $error("flag does not open with SPACE");
  a_flag_mark: assert property (txTick && txState_q == TX_FLAG && txBitCnt_q == 4'h1 && !stuffNow |=>
    serialTxLine_q == MARK && txInProg_q) else $error("second flag bit not MARK");
  a_free_flag: assert property (txTick && txState_q == TX_FLAG && txBitCnt_q == 4'h0 && !stuffNow && txDoneEn_q |=>
    txBufFree_q) else $error("buffer-free not set at flag start");
  a_eom_check: assert property (txTick && txState_q == TX_DATA && !stuffNow && txBitCnt_q == CHAR_LAST && txShiftEom_q
    |=> txState_q == TX_CHECK ##1 !txTick [*1]) else $error("no check after last character");
  a_active_drop: assert property (txTick && txState_q == TX_IDLE && txInProg_q |=> !txInProg_q && txBufFree_q)
    else $error("in-progress not cleared with buffer-free set");
  a_idle_mark: assert property (!txInProg_q && !ctrlSend && txState_q == TX_IDLE |=>
    serialTxLine_q == MARK && txOutBit_q == SPACE) else $error("idle line not held at MARK");
  a_rx_drop: assert property (rxTick && ctrl_q[CTRL_RXEN] && rxFramed_q && rxOnes_q == STUFF_LIMIT && !rxBit &&
    rxWinNext != FLAG_PATTERN |=> rxShift_q == $past(rxShift_q) && rxCnt_q == $past(rxCnt_q))
    else $error("stuffed receive zero was kept");
  a_rx_deliver: assert property (charDone && !rxAddrPh_q |=> rxDone_q && rxBuf_q == $past(rxShiftNext))
    else $error("primary character not delivered");
  a_addr_match: assert property (charDone && rxAddrPh_q && rxShiftNext == param_q |=> rxMsgAct_q && rxFramed_q)
    else $error("address match did not start message");
  a_addr_hidden: assert property (charDone && rxAddrPh_q && !rxBufRead |=> rxBuf_q == $past(rxBuf_q) &&
    rxDone_q == $past(rxDone_q)) else $error("address character was delivered");
  a_check_preset: assert property (txTick && txState_q == TX_FLAG && !stuffNow |=> txCrcVal == CRC_PRESET)
    else $error("check register not preset during flag");

  c_inter_flag: cover property (txTick && txState_q == TX_CHECK && txBitCnt_q == CHECK_LAST && txDoneEn_d);
  c_terminate: cover property (txTick && txState_q == TX_IDLE && txInProg_q);
  c_tx_stuff: cover property (txTick && stuffNow && txState_q == TX_CHECK);
  c_rx_deliver: cover property (charDone && !rxAddrPh_q);
  c_sec_match: cover property (charDone && rxAddrPh_q && rxShiftNext == param_q);
endmodule : sdlcf_framer

// ==== bench/sdlcf_modem.sv ====
`timescale 1ns/1ps
module sdlcf_modem (
  output logic      txClk,        // Free-running transmit bit clock.
  input  wire logic serialTxLine, // Line from the framer.
  output logic      rxClk,        // Receive bit clock, still between bursts.
  output logic      rxData        // Receive data toward the framer.
);
  logic txBits[$];
  int   ones = 0;
  initial txClk = 1'b0;
  initial rxClk = 1'b0;
  initial rxData = 1'b1;
  always #32 txClk = ~txClk;
  always @(posedge txClk) txBits.push_back(serialTxLine);
  task automatic bit_out(input logic b);
    rxData = b;
    #32 rxClk = 1'b1;
    #32 rxClk = 1'b0;
  endtask : bit_out
  // The remote station stuffs data but never flags, so the framer can find frame edges.
  task automatic send_char(input logic [7:0] c, input logic isFlag);
    for (int i = 0; i < 8; i++) begin
      bit_out(c[i]);
      ones = (c[i] && !isFlag) ? ones + 1 : 0;
      if (ones == 5) begin
        bit_out(1'b0);
        ones = 0;
      end
    end
    rxData = ~rxData;
  endtask : send_char
endmodule : sdlcf_modem

// ==== bench/sdlcf_framer_tb.sv ====
`timescale 1ns/1ps
module sdlcf_framer_tb;
  import sdlcf_pkg::*;
  logic              clk = 1'b0, rst = 1'b1, regWr = 1'b0, regRd = 1'b0;
  logic [ADDR_W-1:0] regAddr = '0;
  logic [DATA_W-1:0] regWdata = '0, regRdata;
  logic              txClk, serialTxLine, rxClk, rxData;
  logic [31:0]       seed = 32'h0000_0016;
  logic [7:0]        rxc;
  int                n_errors = 0, samples_checked = 0, cycles = 0;
  sdlcf_framer u_sdlcf_framer (.clk(clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .txClk(txClk), .serialTxLine(serialTxLine), .rxClk(rxClk), .rxData(rxData));
  sdlcf_modem u_sdlcf_modem (.txClk(txClk), .serialTxLine(serialTxLine), .rxClk(rxClk), .rxData(rxData));
  always #4 clk = ~clk;
  task automatic final_report;
    $display("checks %0d, mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : final_report
  always @(posedge clk) begin
    cycles++;
    if (cycles > 60000) begin
      n_errors++;
      final_report();
    end
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  function automatic logic [15:0] crc8(input logic [7:0] c);
    logic [15:0] r;
    r = CRC_PRESET;
    for (int i = 0; i < 8; i++) r = {r[14:0], 1'b0} ^ ((r[15] ^ c[i]) ? CRC_POLY : 16'h0000);
    return r;
  endfunction : crc8
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    @(negedge clk);
    d = regRdata;
  endtask : rd
  task automatic rdc(input logic [4:0] a, input logic [15:0] e, input string w);
    logic [15:0] v;
    rd(a, v);
    chk(w, e, v);
  endtask : rdc
  // Decodes the captured line: hunt a flag, then per frame strip stuffed zeros and expect a flag after it.
  task automatic tx_frame(input logic [7:0] c, input logic [7:0] c2, input int nf);
    logic [15:0] v, gotc;
    logic [7:0]  sr, gotd;
    logic        bad, q[$];
    int          p, k, ones;
    wr(OFS_CTRL, 16'h0001);
    u_sdlcf_modem.txBits.delete();
    wr(OFS_TXBUF, {6'h00, 2'b11, c});
    do rd(OFS_STATUS, v); while (v[1] !== 1'b1);
    if (nf == 2) begin
      // Lands early in the first frame's check sequence, so the second frame is chained.
      repeat (150) @(posedge clk);
      wr(OFS_TXBUF, {6'h00, 2'b11, c2});
      do rd(OFS_STATUS, v); while (v[0] !== 1'b1);
      chk("chain status", 16'h0003, v);
    end
    do rd(OFS_STATUS, v); while (v[1] === 1'b1);
    chk("tx status", 16'h0001, v);
    wr(OFS_CTRL, 16'h0000);
    q = u_sdlcf_modem.txBits;
    sr = '0;
    p = 0;
    while (sr !== FLAG_PATTERN && p < q.size()) sr = {q[p++], sr[7:1]};
    for (int f = 0; f < nf; f++) begin
      k = 0;
      ones = 0;
      bad = 1'b0;
      while (k < 24) begin
        if (ones == 5) {bad, ones} = {bad | q[p], 32'd0};
        else begin
          if (k < 8) gotd[k] = q[p];
          else gotc = {gotc[14:0], q[p]};
          ones = q[p] ? ones + 1 : 0;
          k++;
        end
        p++;
      end
      if (ones == 5) bad |= q[p++];
      for (int i = 0; i < 8; i++) sr[i] = q[p++];
      chk("tx char", {8'h00, (f != 0) ? c2 : c}, {8'h00, gotd});
      chk("tx check", crc8((f != 0) ? c2 : c), gotc);
      chk("stuffed zero", 16'h0000, {15'h0000, bad});
      chk("closing flag", {8'h00, FLAG_PATTERN}, {8'h00, sr});
    end
    repeat (20) @(posedge clk);
    chk("idle line", {15'h0000, MARK}, {15'h0000, serialTxLine});
    $display("test tx frame %h done", c);
  endtask : tx_frame
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rdc(OFS_STATUS, 16'h0001, "reset status");
    rdc(5'h1C, 16'h0000, "unmapped");
    chk("reset line", {15'h0000, MARK}, {15'h0000, serialTxLine});
    tx_frame(8'hFF, 8'h00, 1);
    for (int i = 0; i < 2; i++) begin
      seed = xs(seed);
      tx_frame(seed[7:0], seed[15:8], i + 1);
    end
    for (int m = 0; m < 3; m++) begin
      seed = xs(seed);
      wr(OFS_PARAM, {8'h00, seed[7:0]});
      wr(OFS_CTRL, {13'h0000, m != 0, 2'b10});
      u_sdlcf_modem.send_char(FLAG_PATTERN, 1'b1);
      u_sdlcf_modem.send_char(FLAG_PATTERN, 1'b1);
      u_sdlcf_modem.send_char(m == 2 ? ~seed[7:0] : seed[7:0], 1'b0);
      repeat (8) @(posedge clk);
      if (m == 0) rdc(OFS_RXBUF, {8'h00, seed[7:0]}, "rx address");
      // All ones in the secondary run forces a stuffed zero inside the delivered character.
      rxc = (m == 1) ? 8'hFF : seed[15:8];
      u_sdlcf_modem.send_char(rxc, 1'b0);
      repeat (8) @(posedge clk);
      rdc(OFS_STATUS, {12'h000, m != 2, m != 2, 2'b01}, "rx status");
      if (m != 2) rdc(OFS_RXBUF, {8'h00, rxc}, "rx data");
      u_sdlcf_modem.send_char(FLAG_PATTERN, 1'b1);
      wr(OFS_CTRL, 16'h0000);
      $display("test rx mode %0d done", m);
    end
    final_report();
  end
endmodule : sdlcf_framer_tb
